//--- dcf_channel.sv
// one fifo channel with standard and fall-through timing and offset flags
`include "dcf_regs.svh"

// Overview of operation
// - write enable low and not full stores din at next location.
// - standard mode full_n low while full, high again after a read.
// - full_n goes low after depth writes with no reads.
// - a full memory ignores write enable in both modes.
// - fall-through in_ready_n high once memory plus output hold depth plus one.
// - read enable low and not empty moves next word to output register.
// - standard mode read enable high keeps the output register and dout_bus unchanged.
// - empty_n low after last read, ignores reads while empty, high after write.
// - fall-through first word reaches outputs on third read edge after write.
// - out_ready_n low with first word, high only on a true read.
// - output enable low drives output register, high floats the bus.
// - load and write low alternately load empty then full offset.
// - raising load keeps the write offset pointer for the next load.
// - load low with write enable high changes nothing.
// - load and read low present next offset with own read pointer.
// - offset readback only in standard mode, blocked in fall-through.
// - almost_full_n low at depth minus m, or depth plus one minus m.
// - async almost-full uses true count, sync uses write view only.
// - almost_empty_n low at count up to n, or n plus one.
// - async almost-empty uses true count, sync uses read view only.
// - reset clears pointers and output, loads default offsets and flags.
// - default offsets are 31, 63 or 127 by capacity.
// - three straps at reset pick timing, flag buffering and flag timing.
module dcf_channel #(
    parameter int DEPTH = `DCF_DEPTH,
    parameter int WIDTH = `DCF_DATA_W
) (
    // clock, reset and enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // configuration straps
    input wire logic first_load_n,
    input wire logic rd_chain_in_n,
    input wire logic wr_chain_in_n,
    // write side
    input wire logic wr_en_n,
    input wire logic offset_load_n,
    input wire logic [WIDTH-1:0] din,
    // read side
    input wire logic rd_en_n,
    input wire logic out_en_n,
    // data output
    output logic [WIDTH-1:0] dout_bus,
    output logic dout_oe_n,
    // status flags
    output logic full_n,
    output logic in_ready_n,
    output logic empty_n,
    output logic out_ready_n,
    output logic almost_full_n,
    output logic almost_empty_n,
    output dcf_pkg::dcf_mode_type timing_mode
);
    import dcf_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int OW = `DCF_OFS_W;
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);

    // -----------------------------------------------------------------
    // helper functions
    // -----------------------------------------------------------------

    // default threshold for the capacity option
    function automatic logic [OW-1:0] def_ofs(input int depth);
        if (depth == 256) begin
            return `DCF_OFS_DEF_256;
        end else if (depth == 512) begin
            return `DCF_OFS_DEF_512;
        end
        return `DCF_OFS_DEF_BIG;
    endfunction : def_ofs

    localparam logic [OW-1:0] OFS_DEF = def_ofs(DEPTH);

    // words between two pointers
    function automatic logic [AW:0] span(input logic [AW:0] hi, input logic [AW:0] lo);
        return hi - lo;
    endfunction : span

    // words held, with the output register in fall-through
    function automatic logic [15:0] held(input logic [AW:0] cnt, input logic extra);
        return 16'(cnt) + 16'(extra);
    endfunction : held

    // -----------------------------------------------------------------
    // configuration captured at reset release
    // -----------------------------------------------------------------
    logic cfg_pending;
    logic dbl_flags;
    logic sync_flags;
    logic active;
    logic mode_fall_through_mode;

    // straps sampled on the first enabled edge after reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_pending <= 1'b1;
            timing_mode <= dcf_mode_std;
            dbl_flags <= 1'b0;
            sync_flags <= 1'b0;
        end else if (ce && cfg_pending) begin
            cfg_pending <= 1'b0;
            timing_mode <= mode_fall_through_mode ? dcf_mode_fall_through_mode : dcf_mode_std;
            dbl_flags <= rd_chain_in_n && !wr_chain_in_n;
            sync_flags <= first_load_n && !(rd_chain_in_n && wr_chain_in_n);
        end
    end

    assign active = !cfg_pending;

    // -----------------------------------------------------------------
    // pointers and their crossed views
    // -----------------------------------------------------------------
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic [AW:0] wptr_r;
    logic [AW:0] rptr_w;
    logic [AW:0] next_wptr;
    logic [AW:0] next_rptr;
    logic out_valid;
    logic next_out_valid;
    logic fall_through_mode;

    // read view of the write pointer
    dcf_ptr_sync #(
        .PW(AW + 1)
    ) u_wptr_sync (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .bin_in(next_wptr),
        .bin_out(wptr_r)
    );

    // write view of the read pointer
    dcf_ptr_sync #(
        .PW(AW + 1)
    ) u_rptr_sync (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .bin_in(next_rptr),
        .bin_out(rptr_w)
    );

    // -----------------------------------------------------------------
    // access decode
    // -----------------------------------------------------------------
    logic [AW:0] wr_count;
    logic [AW:0] rd_count;
    logic wr_fifo;
    logic wr_ofs;
    logic rd_std;
    logic rd_ofs;
    logic consume;
    logic fall_through_mode_load;
    logic rd_mem;

    assign fall_through_mode = (timing_mode == dcf_mode_fall_through_mode);
    // strap decode on the capture edge so flags start in the new mode
    assign mode_fall_through_mode = cfg_pending ? (!rd_chain_in_n && wr_chain_in_n) : fall_through_mode;
    assign wr_count = span(wptr, rptr_w);
    assign rd_count = span(wptr_r, rptr);
    // fifo write only with load high and space left
    assign wr_fifo = active && !wr_en_n && offset_load_n && (wr_count != DEPTH_CNT);
    // offset write needs both load and write enable low
    assign wr_ofs = active && !wr_en_n && !offset_load_n;
    // standard read only when words are visible
    assign rd_std = active && !fall_through_mode && !rd_en_n && offset_load_n && (rd_count != '0);
    // offset readback blocked in fall-through
    assign rd_ofs = active && !fall_through_mode && !rd_en_n && !offset_load_n;
    assign consume = !rd_en_n && offset_load_n;
    // fall-through refills an empty or consumed output register
    assign fall_through_mode_load = active && fall_through_mode && (rd_count != '0) && (!out_valid || consume);
    assign rd_mem = rd_std || fall_through_mode_load;

    assign next_wptr = wptr + (AW + 1)'(wr_fifo);
    assign next_rptr = rptr + (AW + 1)'(rd_mem);

    // output register holds its word until a true read
    always_comb begin
        next_out_valid = out_valid;
        if (fall_through_mode_load) begin
            next_out_valid = 1'b1;
        end else if (active && fall_through_mode && consume) begin
            next_out_valid = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // storage
    // -----------------------------------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];

    // words stored in order, independent of reads
    always_ff @(posedge clock) begin
        if (ce && wr_fifo) begin
            mem[wptr[AW-1:0]] <= din;
        end
    end

    // pointer advance
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wptr <= '0;
            rptr <= '0;
            out_valid <= 1'b0;
        end else if (ce) begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            out_valid <= next_out_valid;
        end
    end

    // -----------------------------------------------------------------
    // offset registers
    // -----------------------------------------------------------------
    logic [OW-1:0] empty_threshold_offset;
    logic [OW-1:0] full_threshold_offset;
    logic wr_ofs_sel;
    logic rd_ofs_sel;

    // alternating offset load, pointer kept across load high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            empty_threshold_offset <= OFS_DEF;
            full_threshold_offset <= OFS_DEF;
            wr_ofs_sel <= `DCF_OFS_SEL_EMPTY;
        end else if (ce && wr_ofs) begin
            if (wr_ofs_sel == `DCF_OFS_SEL_EMPTY) begin
                empty_threshold_offset <= din[OW-1:0];
            end else begin
                full_threshold_offset <= din[OW-1:0];
            end
            wr_ofs_sel <= !wr_ofs_sel;
        end
    end

    // separate readback pointer
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_ofs_sel <= `DCF_OFS_SEL_EMPTY;
        end else if (ce && rd_ofs) begin
            rd_ofs_sel <= !rd_ofs_sel;
        end
    end

    // -----------------------------------------------------------------
    // output register and bus enable
    // -----------------------------------------------------------------

    // loaded from memory or offset readback, else held
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dout_bus <= `DCF_DOUT_RST;
        end else if (ce) begin
            if (rd_mem) begin
                dout_bus <= mem[rptr[AW-1:0]];
            end else if (rd_ofs) begin
                if (rd_ofs_sel == `DCF_OFS_SEL_EMPTY) begin
                    dout_bus <= {{(WIDTH - OW){1'b0}}, empty_threshold_offset};
                end else begin
                    dout_bus <= {{(WIDTH - OW){1'b0}}, full_threshold_offset};
                end
            end
        end
    end

    // bus drive enable follows output enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dout_oe_n <= 1'b1;
        end else if (ce) begin
            dout_oe_n <= out_en_n;
        end
    end

    // -----------------------------------------------------------------
    // full and empty flags
    // -----------------------------------------------------------------
    logic [AW:0] next_wr_count;
    logic [AW:0] next_rd_count;
    logic [AW:0] next_true_count;
    logic next_full_n;
    logic next_empty_n;
    logic full_stage;
    logic empty_stage;

    assign next_wr_count = span(next_wptr, rptr_w);
    assign next_rd_count = span(wptr_r, next_rptr);
    assign next_true_count = span(next_wptr, next_rptr);
    assign next_full_n = (next_wr_count != DEPTH_CNT);
    assign next_empty_n = (next_rd_count != '0);

    // standard flags, with optional second buffer stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            full_stage <= 1'b1;
            empty_stage <= 1'b0;
            full_n <= 1'b1;
            empty_n <= 1'b0;
        end else if (ce) begin
            full_stage <= next_full_n;
            empty_stage <= next_empty_n;
            if (mode_fall_through_mode) begin
                full_n <= 1'b1;
                empty_n <= 1'b1;
            end else begin
                full_n <= dbl_flags ? full_stage : next_full_n;
                empty_n <= dbl_flags ? empty_stage : next_empty_n;
            end
        end
    end

    // fall-through ready flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_ready_n <= 1'b0;
            out_ready_n <= 1'b1;
        end else if (ce) begin
            if (mode_fall_through_mode) begin
                in_ready_n <= (next_wr_count == DEPTH_CNT);
                out_ready_n <= !next_out_valid;
            end else begin
                in_ready_n <= 1'b0;
                out_ready_n <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // programmable almost flags
    // -----------------------------------------------------------------
    logic [15:0] af_count;
    logic [15:0] ae_count;
    logic [15:0] af_limit;
    logic [15:0] ae_limit;

    // async config sees true count, sync config only its own side view
    assign af_count = held(sync_flags ? next_wr_count : next_true_count,
                           fall_through_mode && next_out_valid);
    assign ae_count = held(sync_flags ? next_rd_count : next_true_count,
                           fall_through_mode && next_out_valid);
    assign af_limit = 16'(DEPTH_CNT) + 16'(fall_through_mode) - 16'(full_threshold_offset);
    assign ae_limit = 16'(empty_threshold_offset) + 16'(fall_through_mode);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            almost_full_n <= 1'b1;
            almost_empty_n <= 1'b0;
        end else if (ce) begin
            almost_full_n <= !(af_count >= af_limit);
            almost_empty_n <= !(ae_count <= ae_limit);
        end
    end

endmodule : dcf_channel

//--- dcf_regs.svh
// offsets, field positions, reset values and counts of the fifo channel
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// -----------------------------------------------------------------
// geometry
// -----------------------------------------------------------------
`define DCF_DATA_W 18
`define DCF_DEPTH 256
`define DCF_OFS_W 12

// -----------------------------------------------------------------
// default threshold offsets by capacity option
// -----------------------------------------------------------------
`define DCF_OFS_DEF_256 12'h01f
`define DCF_OFS_DEF_512 12'h03f
`define DCF_OFS_DEF_BIG 12'h07f

// -----------------------------------------------------------------
// reset values and pointer crossing
// -----------------------------------------------------------------
`define DCF_DOUT_RST 18'h00000
`define DCF_OFS_SEL_EMPTY 1'b0
`define DCF_OFS_SEL_FULL 1'b1
`define DCF_SYNC_STAGES 2

`endif

//--- dcf_pkg.sv
// types shared by the fifo channel files
package dcf_pkg;

    // -----------------------------------------------------------------
    // timing mode chosen by the straps
    // -----------------------------------------------------------------
    typedef enum logic {
        dcf_mode_std = 1'b0,
        dcf_mode_fall_through_mode = 1'b1
    } dcf_mode_type;

endpackage : dcf_pkg

//--- dcf_ptr_sync.sv
// gray-coded two-stage pointer crossing with binary decode
module dcf_ptr_sync #(
    parameter int PW = 9
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // pointer in and delayed view out
    input wire logic [PW-1:0] bin_in,
    output logic [PW-1:0] bin_out
);
    import dcf_pkg::*;

    logic [PW-1:0] gray_src;
    logic [PW-1:0] gray_s1;
    logic [PW-1:0] gray_s2;

    // gray encode so only one bit moves per step
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gray_src <= '0;
        end else if (ce) begin
            gray_src <= bin_in ^ (bin_in >> 1);
        end
    end

    // two flops; first stage feeds only the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gray_s1 <= '0;
            gray_s2 <= '0;
        end else if (ce) begin
            gray_s1 <= gray_src;
            gray_s2 <= gray_s1;
        end
    end

    // gray back to binary
    always_comb begin
        bin_out[PW-1] = gray_s2[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            bin_out[i] = bin_out[i+1] ^ gray_s2[i];
        end
    end

endmodule : dcf_ptr_sync

//--- dcf_channel_checker.sv
// port assertions for one fifo channel
module dcf_channel_checker #(
    parameter int DEPTH = 256,
    parameter int WIDTH = 18
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // far side requests
    input wire logic wr_en_n,
    input wire logic offset_load_n,
    input wire logic [WIDTH-1:0] din,
    input wire logic rd_en_n,
    input wire logic out_en_n,
    // channel outputs
    input wire logic [WIDTH-1:0] dout_bus,
    input wire logic dout_oe_n,
    input wire logic full_n,
    input wire logic in_ready_n,
    input wire logic empty_n,
    input wire logic out_ready_n,
    input wire dcf_pkg::dcf_mode_type timing_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcf_pkg::*;
    logic std;
    logic [2:0] wr_idle;
    logic [2:0] rd_idle;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    assign std = (timing_mode == dcf_mode_std);
    // quiet cycles without a memory write, saturating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_idle <= 3'h0;
        end else if (!wr_en_n && offset_load_n) begin
            wr_idle <= 3'h0;
        end else if (wr_idle != 3'h7) begin
            wr_idle <= wr_idle + 3'h1;
        end
    end
    // quiet cycles without a memory read, saturating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_idle <= 3'h0;
        end else if (!rd_en_n && offset_load_n) begin
            rd_idle <= 3'h0;
        end else if (rd_idle != 3'h7) begin
            rd_idle <= rd_idle + 3'h1;
        end
    end
    chk_std_hold: assert property (std && rd_en_n |=> $stable(dout_bus))
        else $error("output moved without a read");
    chk_oe_copy: assert property (ce |=> dout_oe_n == $past(out_en_n))
        else $error("output enable not followed");
    chk_full_hold: assert property (std && !full_n && rd_en_n && rd_idle >= 3'h6 |=> !full_n)
        else $error("full flag released without a read");
    chk_empty_ignore: assert property (std && !empty_n && wr_idle >= 3'h6
        && (wr_en_n || !offset_load_n) && offset_load_n |=> !empty_n && $stable(dout_bus))
        else $error("read taken while empty");
    chk_empty_rise: assert property (std && !empty_n && !wr_en_n && offset_load_n
        && full_n |-> ##[1:6] empty_n)
        else $error("empty flag stuck after write");
    chk_first_word: assert property (!std && out_ready_n && wr_idle >= 3'h5 && !wr_en_n
        && offset_load_n |=> out_ready_n [*3] ##1 (!out_ready_n && dout_bus == $past(din, 4)))
        else $error("first word not on third edge");
    chk_ready_hold: assert property (!std && !out_ready_n && rd_en_n
        |=> !out_ready_n && $stable(dout_bus))
        else $error("word left without a true read");
    chk_mode_pins: assert property (std ? (!in_ready_n && out_ready_n) : (full_n && empty_n))
        else $error("flag of the other mode active");
endmodule : dcf_channel_checker

//--- dcf_far_end.sv
// writer and reader logic on the far side of the channel
module dcf_far_end #(
    parameter int WIDTH = 18
) (
    // clock
    input wire logic clock,
    // write side
    output logic wr_en_n,
    output logic offset_load_n,
    output logic [WIDTH-1:0] din,
    // read side
    output logic rd_en_n,
    output logic out_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero
    initial begin
        wr_en_n = 1'b1;
        offset_load_n = 1'b1;
        din = '0;
        rd_en_n = 1'b1;
        out_en_n = 1'b0;
    end
    // output enable wanders
    always @(negedge clock) begin
        out_en_n <= 1'($urandom_range(1));
    end
    // one word per edge while called back to back
    task automatic put_word(input logic [WIDTH-1:0] w);
        @(negedge clock);
        wr_en_n = 1'b0;
        din = w;
    endtask : put_word
    // release; released data changes so no stale word lingers
    task automatic put_idle();
        @(negedge clock);
        wr_en_n = 1'b1;
        din = ~din;
    endtask : put_idle
    // one read pulse per word; in fall-through the word is already shown before the pulse
    task automatic take_word();
        @(negedge clock);
        rd_en_n = 1'b0;
        @(negedge clock);
        rd_en_n = 1'b1;
    endtask : take_word
    // offset load, then a no-op edge, then load raised; never beside a readback
    task automatic put_offset(input logic [11:0] v);
        @(negedge clock);
        offset_load_n = 1'b0;
        wr_en_n = 1'b0;
        din = WIDTH'(v);
        @(negedge clock);
        wr_en_n = 1'b1;
        din = ~din;
        @(negedge clock);
        offset_load_n = 1'b1;
    endtask : put_offset
    // offset readback on its own cycle
    task automatic get_offset();
        @(negedge clock);
        offset_load_n = 1'b0;
        rd_en_n = 1'b0;
        @(negedge clock);
        offset_load_n = 1'b1;
        rd_en_n = 1'b1;
    endtask : get_offset
endmodule : dcf_far_end

//--- dcf_channel_tb_top.sv
// self-checking bench for the fifo channel
`include "dcf_regs.svh"
module dcf_channel_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcf_pkg::*;
    localparam int DEPTH = `DCF_DEPTH;
    localparam int WIDTH = `DCF_DATA_W;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic first_load_n = 1'b0;
    logic rd_chain_in_n = 1'b0;
    logic wr_chain_in_n = 1'b0;
    logic wr_en_n, offset_load_n, rd_en_n, out_en_n, dout_oe_n;
    logic full_n, in_ready_n, empty_n, out_ready_n, almost_full_n, almost_empty_n;
    logic [WIDTH-1:0] din, dout_bus, last;
    logic [WIDTH-1:0] q[$];
    logic [11:0] n_ofs, m_ofs;
    dcf_mode_type timing_mode;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int cnt;
    bit fw;
    dcf_channel #(.DEPTH(DEPTH), .WIDTH(WIDTH)) i_dut (
        .clock(clock), .rst(rst), .ce(ce), .first_load_n(first_load_n),
        .rd_chain_in_n(rd_chain_in_n), .wr_chain_in_n(wr_chain_in_n), .wr_en_n(wr_en_n),
        .offset_load_n(offset_load_n), .din(din), .rd_en_n(rd_en_n), .out_en_n(out_en_n),
        .dout_bus(dout_bus), .dout_oe_n(dout_oe_n), .full_n(full_n), .in_ready_n(in_ready_n),
        .empty_n(empty_n), .out_ready_n(out_ready_n), .almost_full_n(almost_full_n),
        .almost_empty_n(almost_empty_n), .timing_mode(timing_mode));
    dcf_far_end #(.WIDTH(WIDTH)) i_far (
        .clock(clock), .wr_en_n(wr_en_n), .offset_load_n(offset_load_n), .din(din),
        .rd_en_n(rd_en_n), .out_en_n(out_en_n));
    // ----------------------------------------------------------------
    // clock, watchdog and reporting
    // ----------------------------------------------------------------
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [WIDTH-1:0] seen,
                         input logic [WIDTH-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // ----------------------------------------------------------------
    // stimulus helpers
    // ----------------------------------------------------------------
    task automatic do_reset(input logic [2:0] s);
        rst = 1'b1;
        {first_load_n, rd_chain_in_n, wr_chain_in_n} = s;
        fw = (s[1:0] == 2'b01);
        cnt = 0;
        q.delete();
        repeat (5) @(negedge clock);
        check("almost_full_n", almost_full_n, 1'b1);
        check("almost_empty_n", almost_empty_n, 1'b0);
        check("dout_bus", dout_bus, `DCF_DOUT_RST);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        check("timing_mode", timing_mode, fw);
        check("empty_n", empty_n, fw);
    endtask : do_reset
    task automatic rd_ofs(input logic [11:0] v);
        i_far.get_offset();
        check("offset readback", dout_bus, WIDTH'(v));
    endtask : rd_ofs
    // flags against the count once the crossing has settled
    task automatic levels();
        repeat (8) @(negedge clock);
        check("almost_full_n", almost_full_n, !(cnt >= DEPTH + fw - m_ofs));
        check("almost_empty_n", almost_empty_n, !(cnt <= n_ofs + fw));
        check("full_n", full_n, fw || cnt != DEPTH);
        check("in_ready_n", in_ready_n, fw && cnt == DEPTH + 1);
        check("empty_n", empty_n, fw || cnt != 0);
        check("out_ready_n", out_ready_n, !fw || cnt == 0);
    endtask : levels
    task automatic push(input int k);
        logic [WIDTH-1:0] w;
        repeat (k) begin
            w = WIDTH'($urandom);
            if (cnt < DEPTH + fw) begin
                q.push_back(w);
                cnt++;
            end
            i_far.put_word(w);
        end
        i_far.put_idle();
    endtask : push
    task automatic pop(input int k);
        repeat (k) begin
            if (fw) check("dout_bus", dout_bus, q[0]);
            i_far.take_word();
            if (!fw) check("dout_bus", dout_bus, q[0]);
            last = q.pop_front();
            cnt--;
        end
    endtask : pop
    // ----------------------------------------------------------------
    // every strap code: offsets, fill past full, drain past empty
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(31645));
        for (int s = 0; s < 8; s++) begin
            do_reset(3'(s));
            n_ofs = `DCF_OFS_DEF_256;
            m_ofs = n_ofs;
            if (!fw) begin
                rd_ofs(n_ofs);
                rd_ofs(m_ofs);
            end
            n_ofs = 12'($urandom_range(40, 2));
            m_ofs = 12'($urandom_range(40, 2));
            i_far.put_offset(n_ofs);
            i_far.put_offset(m_ofs);
            rd_ofs(fw ? 12'h000 : n_ofs);
            if (!fw) rd_ofs(m_ofs);
            levels();
            push(DEPTH + fw - m_ofs - 1);
            levels();
            push(1);
            levels();
            push(m_ofs + 1);
            levels();
            pop(cnt - n_ofs - fw - 1);
            levels();
            // clock enable low freezes the read
            ce = 1'b0;
            i_far.take_word();
            check("dout_bus", dout_bus, fw ? q[0] : last);
            ce = 1'b1;
            pop(1);
            levels();
            pop(cnt);
            levels();
            i_far.take_word();
            check("dout_bus", dout_bus, last);
        end
        conclude();
    end
endmodule : dcf_channel_tb_top

bind dcf_channel dcf_channel_checker #(.DEPTH(DEPTH), .WIDTH(WIDTH)) i_chk (
    .clock(clock), .rst(rst), .ce(ce), .wr_en_n(wr_en_n), .offset_load_n(offset_load_n), .din(din),
    .rd_en_n(rd_en_n), .out_en_n(out_en_n), .dout_bus(dout_bus), .dout_oe_n(dout_oe_n),
    .full_n(full_n), .in_ready_n(in_ready_n), .empty_n(empty_n), .out_ready_n(out_ready_n),
    .timing_mode(timing_mode));
